// ==== core/agcc_consts.vh ====
// Purpose: Constants for the address generation and canonical check datapath
// Assumes: Included by bare name from core/agcc_core.v
// Notes: Mode, scale and displacement size encodings plus address widths
`ifndef AGCC_CONSTS_VH
`define AGCC_CONSTS_VH

// Operating modes
`define AGCC_MODE_REAL 2'h0
`define AGCC_MODE_PROT 2'h1
`define AGCC_MODE_COMPAT 2'h2
`define AGCC_MODE_LONG 2'h3

// Scale encodings (shift amounts)
`define AGCC_SCALE_1 2'h0
`define AGCC_SCALE_2 2'h1
`define AGCC_SCALE_4 2'h2
`define AGCC_SCALE_8 2'h3

// Displacement size encodings
`define AGCC_DISP_NONE 2'h0
`define AGCC_DISP_8 2'h1
`define AGCC_DISP_16 2'h2
`define AGCC_DISP_32 2'h3

// Address widths
`define AGCC_REAL_PA_BITS 20
`define AGCC_REAL_SHIFT 4
`define AGCC_PROT_VA_BITS 32
`define AGCC_PAE_PA_BITS 40
`define AGCC_MAX_PA_BITS 52
`define AGCC_VA_BITS_DEFAULT 7'h30
`define AGCC_VA_BITS_MIN 7'h20
`define AGCC_VA_BITS_MAX 7'h40

`endif

// ==== core/agcc_core.v ====
// Purpose: Effective, linear and physical address generation with canonical check
// Assumes: Operands valid with req_valid; one request per cycle, result one cycle later
// Notes: Descriptor lookup, limits, page walk and privilege are outside this block
// Operation
// RULE1 - Effective address is base plus scaled index plus displacement.
// RULE2 - Scale is one, two, four or eight from a two-bit code.
// RULE3 - Index is signed two's complement from any general register.
// RULE4 - Displacement is 8, 16 or 32 bits, sign-extended before adding.
// RULE5 - Long mode produces a 64-bit effective address.
// RULE6 - Selector picks a global or local descriptor entry giving the base.
// RULE7 - Linear address equals segment base plus effective address.
// RULE8 - Flat model, as in 64-bit mode, uses zero segment base.
// RULE9 - With paging off the linear address is the physical address.
// RULE10 - Protected mode virtual addresses are 32 bits wide.
// RULE11 - Long mode virtual addresses are 64 bits; implemented count is reported.
// RULE12 - Real mode physical addresses are 20 bits; only from legacy mode.
// RULE13 - Legacy protected mode physical addresses are 32 bits wide.
// RULE14 - With physical address extension, physical addresses are 40 bits here; code keeps them at 32 bits outside long mode.
// RULE15 - Long mode allows 52-bit physical, needs paging and extension.
// RULE16 - Canonical means bits 63 down to top implemented bit all equal.
// RULE17 - Non-canonical address raises general protection fault, access blocked.
// RULE18 - Non-canonical implied stack reference raises stack fault instead.
// RULE19 - Push, pop, stack pointer or frame base as base are stack refs.
// RULE20 - Sum wraps to current address size before base add and check.
// RULE21 - Real mode base is selector shifted left four plus 16-bit offset.
`timescale 1ns/1ps
`include "agcc_consts.vh"

module agcc_core (
  input wire clk_sys,
  input wire resetn,
  input wire req_valid,
  input wire [1:0] op_mode,
  input wire paging_enable,
  input wire physical_address_extension,
  input wire [63:0] base_value,
  input wire base_present,
  input wire base_is_stack_pointer_reg,
  input wire base_is_frame_base_reg,
  input wire [63:0] index_value,
  input wire index_present,
  input wire [1:0] scale_code,
  input wire [31:0] disp_raw,
  input wire [1:0] disp_size,
  input wire is_push_pop,
  input wire addr_size_16,
  input wire [15:0] seg_selector,
  input wire [63:0] seg_base_desc,
  output wire [6:0] feature_va_bits,
  output reg res_valid,
  output reg [63:0] eff_addr_r,
  output reg [63:0] lin_addr_r,
  output reg [63:0] phys_addr_r,
  output reg phys_valid_r,
  output reg general_protection_fault,
  output reg stack_fault,
  output reg access_ok_r,
  output reg mode_illegal_r
);

  // Implemented virtual bits, reported to the identification query
  localparam [6:0] VA_BITS = `AGCC_VA_BITS_DEFAULT;
  assign feature_va_bits = VA_BITS; // RULE11

  reg [63:0] disp_ext;
  reg [63:0] idx_scaled;
  reg [63:0] ea_sum;
  reg [63:0] ea_nxt;
  reg [63:0] seg_base;
  reg [63:0] lin_nxt;
  reg [63:0] pa_nxt;
  reg [63:0] canon_mask;
  reg [63:0] upper_bits;
  reg noncanon;
  reg stack_ref;
  reg long_mode;
  reg bad_mode;

  // Displacement sign extension
  always @*
  begin
    case (disp_size)
      `AGCC_DISP_8: disp_ext = {{56{disp_raw[7]}}, disp_raw[7:0]}; // RULE4
      `AGCC_DISP_16: disp_ext = {{48{disp_raw[15]}}, disp_raw[15:0]}; // RULE4
      `AGCC_DISP_32: disp_ext = {{32{disp_raw[31]}}, disp_raw[31:0]}; // RULE4
      default: disp_ext = 64'h0000000000000000;
    endcase
  end

  // Signed index times 1, 2, 4 or 8; shift keeps two's complement
  always @*
  begin
    if (!index_present)
      idx_scaled = 64'h0000000000000000;
    else
    begin
      case (scale_code) // RULE2
        `AGCC_SCALE_2: idx_scaled = {index_value[62:0], 1'b0}; // RULE3
        `AGCC_SCALE_4: idx_scaled = {index_value[61:0], 2'b00}; // RULE3
        `AGCC_SCALE_8: idx_scaled = {index_value[60:0], 3'b000}; // RULE3
        default: idx_scaled = index_value; // RULE3
      endcase
    end
  end

  // Effective address sum, wrapped to the current address size
  always @*
  begin
    long_mode = (op_mode == `AGCC_MODE_LONG);
    ea_sum = (base_present ? base_value : 64'h0000000000000000)
      + idx_scaled + disp_ext; // RULE1
    if (op_mode == `AGCC_MODE_REAL || addr_size_16)
      ea_nxt = {48'h000000000000, ea_sum[15:0]}; // RULE20
    else if (long_mode)
      ea_nxt = ea_sum; // RULE5
    else
      ea_nxt = {32'h00000000, ea_sum[31:0]}; // RULE20
  end

  // Segment base selection and linear address
  always @*
  begin
    case (op_mode)
      `AGCC_MODE_REAL:
        seg_base = {44'h00000000000, seg_selector, 4'h0}; // RULE21
      `AGCC_MODE_LONG:
        seg_base = 64'h0000000000000000; // RULE8
      default:
        seg_base = {32'h00000000, seg_base_desc[31:0]}; // RULE6
    endcase
    lin_nxt = seg_base + ea_nxt; // RULE7
    if (op_mode == `AGCC_MODE_REAL)
      lin_nxt = {44'h00000000000, lin_nxt[19:0]}; // RULE12
    else if (!long_mode)
      lin_nxt = {32'h00000000, lin_nxt[31:0]}; // RULE10
  end

  // Canonical form check over bits 63 down to top implemented bit
  always @*
  begin
    canon_mask = ~((64'h0000000000000001 << (VA_BITS - 7'h01)) - 64'h0000000000000001);
    upper_bits = lin_nxt & canon_mask;
    noncanon = long_mode && !((upper_bits == 64'h0000000000000000)
      || (upper_bits == canon_mask)); // RULE16
    stack_ref = is_push_pop || (base_present
      && (base_is_stack_pointer_reg || base_is_frame_base_reg)); // RULE19
  end

  // Physical address when paging is off, and mode legality
  always @*
  begin
    bad_mode = long_mode && !(paging_enable && physical_address_extension); // RULE15
    pa_nxt = lin_nxt; // RULE9
    if (op_mode == `AGCC_MODE_REAL)
      pa_nxt = {44'h00000000000, lin_nxt[19:0]}; // RULE12
    else if (!long_mode)
      pa_nxt = {32'h00000000, lin_nxt[31:0]}; // RULE13 RULE14
  end

  // Result registers
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      res_valid <= 1'b0;
      eff_addr_r <= 64'h0000000000000000;
      lin_addr_r <= 64'h0000000000000000;
      phys_addr_r <= 64'h0000000000000000;
      phys_valid_r <= 1'b0;
      general_protection_fault <= 1'b0;
      stack_fault <= 1'b0;
      access_ok_r <= 1'b0;
      mode_illegal_r <= 1'b0;
    end
    else
    begin
      res_valid <= req_valid;
      general_protection_fault <= 1'b0;
      stack_fault <= 1'b0;
      access_ok_r <= 1'b0;
      phys_valid_r <= 1'b0;
      if (req_valid)
      begin
        eff_addr_r <= ea_nxt;
        lin_addr_r <= lin_nxt;
        phys_addr_r <= pa_nxt;
        mode_illegal_r <= bad_mode;
        general_protection_fault <= noncanon && !stack_ref; // RULE17
        stack_fault <= noncanon && stack_ref; // RULE18
        access_ok_r <= !noncanon && !bad_mode; // RULE17
        phys_valid_r <= !noncanon && !bad_mode && !paging_enable; // RULE9
      end
    end
  end

endmodule

// ==== tb/agcc_pipe_model.sv ====
// Purpose: Issue side of the decode and execute pipeline
// Assumes: fire lasts one cycle
// Notes: Answers are judged by the bench
`timescale 1ns/1ps
module agcc_pipe_model (
  input wire clk_sys,
  input wire resetn,
  input wire fire,
  output reg req_valid
);
  // Request strobe one cycle after fire
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
      req_valid <= 1'b0;
    else
      req_valid <= fire;
endmodule

// ==== tb/agcc_core_monitor.sv ====
// Purpose: Port checker for agcc_core
// Assumes: 48 implemented virtual bits
// Notes: Attached by bind below
`timescale 1ns/1ps
module agcc_core_monitor (
  input wire clk_sys, resetn, req_valid, paging_enable, physical_address_extension,
  input wire base_is_stack_pointer_reg, base_is_frame_base_reg, is_push_pop, res_valid,
  input wire phys_valid_r, general_protection_fault, stack_fault,
  input wire [1:0] op_mode,
  input wire [63:0] eff_addr_r, lin_addr_r, phys_addr_r
);
  // Canonical test and stack reference class
  wire canon_w = ~|lin_addr_r[63:47] | &lin_addr_r[63:47];
  wire stk_w = base_is_stack_pointer_reg | base_is_frame_base_reg | is_push_pop;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_long;
    req_valid && op_mode == 2'h3 && paging_enable && physical_address_extension;
  endsequence
  property p_lat; res_valid == $past(req_valid); endproperty
  a_lat: assert property (p_lat) else $error("late answer");
  property p_can; s_long |=> (general_protection_fault | stack_fault) != canon_w; endproperty
  a_can: assert property (p_can) else $error("canonical");
  property p_ss; stack_fault |-> $past(stk_w); endproperty
  a_ss: assert property (p_ss) else $error("stack fault");
  property p_gp; general_protection_fault |-> !$past(stk_w) && $past(op_mode) == 2'h3;
  endproperty
  a_gp: assert property (p_gp) else $error("protection fault");
  property p_flat; req_valid && op_mode == 2'h3 |=> lin_addr_r == eff_addr_r; endproperty
  a_flat: assert property (p_flat) else $error("flat");
  property p_prot; req_valid && op_mode == 2'h1 |=> lin_addr_r[63:32] == 32'h0; endproperty
  a_prot: assert property (p_prot) else $error("prot width");
  property p_real; req_valid && op_mode == 2'h0 |=> lin_addr_r[63:20] == 44'h0; endproperty
  a_real: assert property (p_real) else $error("real width");
  property p_phys; phys_valid_r |-> phys_addr_r == lin_addr_r && !$past(paging_enable);
  endproperty
  a_phys: assert property (p_phys) else $error("physical");
endmodule
bind agcc_core agcc_core_monitor i_agcc_core_monitor (.*);

// ==== tb/address_generation_canonical_check_tb_top.sv ====
// Purpose: Self-checking bench for agcc_core
// Assumes: One answer a cycle after each strobe
// Notes: Displacement field reads -128 at every size
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected %0t value mismatch %h", $time, a); end end
module address_generation_canonical_check_tb_top;
  reg clk_sys = 1'b0, resetn = 1'b0, fire = 1'b0, base_present = 1'b1, index_present = 1'b1;
  reg addr_size_16 = 1'b0, paging_enable = 1'b0, physical_address_extension = 1'b0;
  reg is_push_pop = 1'b0, base_is_stack_pointer_reg = 1'b0, base_is_frame_base_reg = 1'b0;
  reg [1:0] op_mode = 2'h0, scale_code = 2'h0, disp_size = 2'h0;
  reg [15:0] seg_selector = 16'h0;
  reg [31:0] disp_raw = 32'hFFFF_FF80;
  reg [63:0] base_value = 64'h0, index_value = 64'h0, seg_base_desc = 64'hF000_0000, e;
  wire req_valid, res_valid, phys_valid_r, general_protection_fault, stack_fault;
  wire access_ok_r, mode_illegal_r;
  wire [6:0] feature_va_bits;
  wire [63:0] eff_addr_r, lin_addr_r, phys_addr_r;
  integer num_errors = 0, checks_done = 0, n, k;
  always #25 clk_sys = ~clk_sys;
  agcc_core i_agcc_core (.*);
  agcc_pipe_model i_agcc_pipe_model (.*);
  // One request, bounded wait for its answer
  task req(input [3:0] m, input [63:0] b, input [63:0] x, input [1:0] s, input [2:0] rf);
    begin
      @(posedge clk_sys);
      {op_mode, paging_enable, physical_address_extension, base_value, index_value} <= {m, b, x};
      {scale_code, disp_size, is_push_pop, base_is_frame_base_reg, base_is_stack_pointer_reg}
        <= {s, s, rf};
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      for (n = 0; n < 4 && res_valid !== 1'b1; n++) @(posedge clk_sys) #1;
      num_errors = num_errors + (n == 4);
      if (n == 4) tally_and_finish;
    end
  endtask
  // Each scale and displacement size, negative index
  task t_long;
    for (k = 0; k < 4; k++)
    begin
      req(4'hF, 64'h1000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFD, k[1:0], 3'h0);
      e = 64'h1000_0000_0000 - (64'h3 << k) - (k ? 64'h80 : 64'h0);
      `CK(eff_addr_r, e)
      `CK({lin_addr_r, access_ok_r}, {e, 1'b1})
    end
  endtask
  // Non-canonical base, plain and as each stack reference
  task t_canon;
    for (k = 0; k < 4; k++)
    begin
      req(4'hF, 64'h8000_0000_0000, 64'h0, 2'h0, k[2:0] == 3'h3 ? 3'h4 : k[2:0]);
      `CK({general_protection_fault, stack_fault, access_ok_r}, k ? 3'h2 : 3'h4)
    end
  endtask
  // Segment base and 32-bit wrap, paging off then on, long mode lacking paging
  task t_prot;
    begin
      req(4'h4, 64'h1_2000_0000, 64'h4, 2'h2, 3'h0);
      `CK({eff_addr_r, lin_addr_r, phys_valid_r}, {64'h1FFF_FF90, 64'h0FFF_FF90, 1'b1})
      `CK(phys_addr_r, 64'h0FFF_FF90)
      req(4'h6, 64'h1_2000_0000, 64'h4, 2'h2, 3'h0);
      `CK({phys_valid_r, access_ok_r}, 2'h1)
      req(4'hD, 64'h1000, 64'h0, 2'h0, 3'h0);
      `CK({mode_illegal_r, access_ok_r, general_protection_fault}, 3'h4)
    end
  endtask
  // Selector times sixteen plus 16-bit offset, kept to 20 bits
  task t_real;
    begin
      @(posedge clk_sys);
      seg_selector <= 16'hFFFF;
      req(4'h0, 64'h20, 64'h1_0000, 2'h0, 3'h0);
      `CK({eff_addr_r, lin_addr_r, phys_addr_r}, {64'h20, 64'h10, 64'h10})
    end
  endtask
  // Compatibility 16-bit wrap, then no base and no index
  task t_mix;
    begin
      @(posedge clk_sys);
      addr_size_16 <= 1'b1;
      req(4'h8, 64'h1_2000_0000, 64'h4, 2'h2, 3'h0);
      `CK({eff_addr_r, lin_addr_r, phys_valid_r}, {64'hFF90, 64'hF000_FF90, 1'b1})
      @(posedge clk_sys);
      {addr_size_16, base_present, index_present} <= 3'h0;
      req(4'hF, 64'h8000_0000_0000, 64'h8000_0000_0000, 2'h3, 3'h2);
      `CK({eff_addr_r, access_ok_r, stack_fault}, {64'hFFFF_FFFF_FFFF_FF80, 2'h2})
    end
  endtask
  // Verdict and end of run
  task tally_and_finish;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Reset, then each scenario in turn
  initial
  begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    t_long;
    t_canon;
    t_prot;
    t_real;
    t_mix;
    `CK(feature_va_bits, 7'h30)
    tally_and_finish;
  end
endmodule
